// File: hw/spigp_pkg.sv
// Shared constants for the serial port with general-purpose pad mode.
// Assumes a single system clock; figures here are counts of clock cycles, bits, pads or entries, except CLK_PERIOD_NS in ns.
package spigp_pkg;
	localparam int BYTE_W = 8;
	localparam int PAD_N = 4;
	localparam int RX_FIFO_DEPTH = 32;
	localparam int CLK_PERIOD_NS = 10;
	// Pad to data-bit mapping.
	localparam int PAD_NSS = 3;
	localparam int PAD_MOSI = 2;
	localparam int PAD_MISO = 1;
	localparam int PAD_SCK = 0;
	// Output enables used in master mode: select, data out and clock.
	localparam logic [PAD_N-1:0] MST_OE = 4'hd;
	// Reset values.
	localparam logic [PAD_N-1:0] DIR_RST = 4'h0;
	localparam logic [PAD_N-1:0] PULLUP_RST = 4'hf;
	localparam logic [PAD_N-1:0] PAD_SYNC_RST = 4'hf;
	localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;
	localparam logic TX_EMPTY_RST = 1'b1;
	// Master clock: half period is BAUD_HALF_BASE cycles shifted left by the baud field.
	// Four cycles is the floor, because the slave's answer comes back through the pad
	// output register and the two-flop synchroniser before the next sampling edge.
	localparam logic [5:0] BAUD_HALF_BASE = 6'h04;
	localparam logic [5:0] DIV_START = 6'h01;
	// Sixteen clock edges make one byte.
	localparam logic [3:0] EDGE_FIRST = 4'h0;
	localparam logic [3:0] EDGE_LAST = 4'hf;
endpackage : spigp_pkg

// File: hw/spigp_sync.sv
// Two-flip-flop synchroniser for a group of asynchronous levels.
// Assumes the reset is already synchronous to clk in its release.
`timescale 1ns/10ps
module spigp_sync #(
	parameter int W = 4,
	parameter logic [W-1:0] RST_VAL = '0
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic meta_r;
			logic hold_r;
			always_ff @(posedge clk or negedge rst_n)
			begin
				if (!rst_n)
				begin
					meta_r <= RST_VAL[i];
					hold_r <= RST_VAL[i];
				end
				else
				begin
					meta_r <= d[i];
					hold_r <= meta_r;
				end
			end
			assign q[i] = hold_r;
		end
	endgenerate
endmodule : spigp_sync

// File: hw/spigp_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; depth is a power of two.
`timescale 1ns/10ps
module spigp_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr_r;
	logic [AW-1:0] rd_ptr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	assign in_ready = (count_r != (AW+1)'(DEPTH));
	assign out_valid = (count_r != '0);
	assign out_data = mem[rd_ptr_r];
	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr_r] <= in_data;
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_ptr_r <= '0;
			rd_ptr_r <= '0;
			count_r <= '0;
		end
		else
		begin
			if (push)
				wr_ptr_r <= wr_ptr_r + AW'(1);
			if (pop)
				rd_ptr_r <= rd_ptr_r + AW'(1);
			if (push & !pop)
				count_r <= count_r + (AW+1)'(1);
			else if (pop & !push)
				count_r <= count_r - (AW+1)'(1);
		end
	end
endmodule : spigp_fifo

// File: hw/spigp_top.sv
// Byte-wide serial port, master or slave, that falls back to a 4-bit pad port.
// Assumes software strobes are one-cycle pulses on clk_sys and the pads arrive
// unsynchronised; pad drivers and pull-ups sit outside and obey pad_oe/pad_pullup_en.
`timescale 1ns/10ps

// Notes on behaviour
// R1: Software waits for rx full before next transfer.
// R2: Master trigger loads shifter, starts, sets empty.
// R3: Reading receive data clears rx full.
// R4: Writing transmit data drops tx empty.
// R5: Slave needs manual load only for first byte.
// R6: Slave byte end reloads shifter, sets empty.
// R7: Software configures slave mode to match master.
// R8: Serial mode off means 4-bit pad port.
// R9: Per-pad direction bit, one means output.
// R10: Port reset clears all direction bits.
// R11: Output pads drive transmit data bits.
// R12: Pad input register reads pads unfiltered.
// R13: Pull-up follows its bit, off when output.
// R14: All pull-ups enabled after reset.
// R15: Pull-ups also apply in serial mode.
// R16: Select bit3, MOSI bit2, MISO bit1, clock bit0.
// R17: Receive interrupt when rx full sets.
// R18: Slave counters held while select high.
// R19: Master stops clock, stores byte at end.
// R20: Bytes move most significant bit first.
module spigp_top (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic pconf_resetn,
	input wire logic serial_mode_select,
	input wire logic master_select,
	input wire logic clock_phase,
	input wire logic clock_polarity,
	input wire logic [1:0] baud_rate,
	input wire logic slave_select_ctl,
	input wire logic clear_counters,
	input wire logic tx_data_wr,
	input wire logic [spigp_pkg::BYTE_W-1:0] tx_data_in,
	input wire logic tx_trigger_wr,
	input wire logic rx_data_rd,
	input wire logic pad_direction_wr,
	input wire logic [spigp_pkg::PAD_N-1:0] pad_direction_in,
	input wire logic pad_pullup_wr,
	input wire logic [spigp_pkg::PAD_N-1:0] pad_pullup_in,
	input wire logic [spigp_pkg::PAD_N-1:0] pad_in,
	output logic [spigp_pkg::PAD_N-1:0] pad_out,
	output logic [spigp_pkg::PAD_N-1:0] pad_oe,
	output logic [spigp_pkg::PAD_N-1:0] pad_pullup_en,
	output logic tx_empty_flag,
	output logic rx_full_flag,
	output logic rx_irq,
	output logic [spigp_pkg::BYTE_W-1:0] rx_data_reg,
	output logic [spigp_pkg::PAD_N-1:0] pad_input_reg,
	output logic [spigp_pkg::PAD_N-1:0] pad_direction_reg,
	output logic [spigp_pkg::PAD_N-1:0] pad_pullup_reg
);
	import spigp_pkg::*;

	typedef enum logic [2:0] {
		M_IDLE = 3'b001,
		M_HOLD = 3'b010,
		M_RUN = 3'b100
	} spigp_mst_t;

	logic [1:0] grst_q;
	logic [1:0] prst_q;
	logic rst_n;
	logic pconf_rst_n;
	logic [PAD_N-1:0] pad_s;
	logic [BYTE_W-1:0] tx_data_r;
	logic [PAD_N-1:0] dir_r;
	logic [PAD_N-1:0] pullup_r;
	logic [BYTE_W-1:0] sh_r;
	logic bit_r;
	logic [3:0] cnt_r;
	logic [5:0] div_r;
	logic sck_r;
	logic sck_d_r;
	spigp_mst_t state_r;
	spigp_mst_t state_nxt;
	logic tx_empty_r;
	logic rx_full_r;
	logic rx_irq_r;
	logic [BYTE_W-1:0] rx_byte_r;
	logic [PAD_N-1:0] pad_out_r;
	logic [PAD_N-1:0] pad_oe_r;
	logic [PAD_N-1:0] pull_r;
	logic [PAD_N-1:0] pad_in_r;
	logic [PAD_N-1:0] out_nxt;
	logic [PAD_N-1:0] oe_nxt;
	logic is_mst;
	logic is_slv;
	logic slv_sel;
	logic slv_edge;
	logic mst_tick;
	logic edge_go;
	logic in_bit;
	logic sample_edge;
	logic shift_edge;
	logic last_edge;
	logic cnt_hold;
	logic [5:0] half_cyc;
	logic [BYTE_W-1:0] done_byte;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_out_ready;
	logic [BYTE_W-1:0] fifo_out_data;
	logic pop;
	logic load_sw;

	////////////////////////////////////////////////////////////////////////////
	// Reset release and pad synchronisation.

	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			grst_q <= 2'b00;
		else
			grst_q <= {grst_q[0], 1'b1};
	end

	always_ff @(posedge clk_sys or negedge pconf_resetn)
	begin
		if (!pconf_resetn)
			prst_q <= 2'b00;
		else
			prst_q <= {prst_q[0], 1'b1};
	end

	assign rst_n = grst_q[1];
	assign pconf_rst_n = prst_q[1];

	// Idle-high reset value keeps a slave deselected until real pad levels arrive.
	spigp_sync #(
		.W(PAD_N),
		.RST_VAL(PAD_SYNC_RST)
	) u_pad_sync (
		.clk(clk_sys),
		.rst_n(rst_n),
		.d(pad_in),
		.q(pad_s)
	);

	////////////////////////////////////////////////////////////////////////////
	// Software-written configuration.

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			tx_data_r <= BYTE_RST;
		else if (tx_data_wr)
			tx_data_r <= tx_data_in;
	end

	always_ff @(posedge clk_sys or negedge pconf_rst_n)
	begin
		if (!pconf_rst_n)
		begin
			dir_r <= DIR_RST; // see R10
			pullup_r <= PULLUP_RST; // see R14
		end
		else
		begin
			if (pad_direction_wr)
				dir_r <= pad_direction_in;
			if (pad_pullup_wr)
				pullup_r <= pad_pullup_in;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Edge generation: master divider or sampled slave clock.

	assign is_mst = serial_mode_select & master_select;
	assign is_slv = serial_mode_select & ~master_select;
	assign half_cyc = BAUD_HALF_BASE << baud_rate;
	assign mst_tick = (state_r == M_RUN) & (div_r == half_cyc) & ~clear_counters;
	assign slv_sel = is_slv & ~pad_s[PAD_NSS] & ~clear_counters;
	// The slave clock must be well below a quarter of clk_sys or edges merge.
	assign slv_edge = slv_sel & (pad_s[PAD_SCK] ^ sck_d_r);
	assign edge_go = mst_tick | slv_edge;
	assign in_bit = is_mst ? pad_s[PAD_MISO] : pad_s[PAD_MOSI];
	assign sample_edge = clock_phase ? cnt_r[0] : ~cnt_r[0];
	assign shift_edge = clock_phase ? (~cnt_r[0] & (cnt_r != EDGE_FIRST)) : cnt_r[0];
	assign last_edge = edge_go & (cnt_r == EDGE_LAST);
	assign done_byte = {sh_r[BYTE_W-2:0], clock_phase ? in_bit : bit_r}; // see R20
	assign cnt_hold = clear_counters | ~serial_mode_select | (is_slv & pad_s[PAD_NSS]);
	assign load_sw = tx_trigger_wr & serial_mode_select;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			sck_d_r <= PAD_SYNC_RST[PAD_SCK];
		else
			sck_d_r <= pad_s[PAD_SCK];
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= EDGE_FIRST;
		else if (cnt_hold)
			cnt_r <= EDGE_FIRST; // see R18
		else if (edge_go)
			cnt_r <= cnt_r + 4'h1;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_r <= DIV_START;
			sck_r <= 1'b0;
		end
		else if ((state_r != M_RUN) | clear_counters)
		begin
			div_r <= DIV_START;
			sck_r <= 1'b0; // see R19
		end
		else if (mst_tick)
		begin
			div_r <= DIV_START;
			sck_r <= ~sck_r;
		end
		else
			div_r <= div_r + 6'h01;
	end

	////////////////////////////////////////////////////////////////////////////
	// Master sequencing. A byte only starts when the receive FIFO has room.

	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			M_IDLE:
				if (tx_trigger_wr & is_mst)
					state_nxt = M_HOLD; // see R2
			M_HOLD:
				if (fifo_in_ready)
					state_nxt = M_RUN;
			M_RUN:
				if (last_edge)
					state_nxt = M_IDLE; // see R19
			default:
				state_nxt = M_IDLE;
		endcase
		if (!is_mst)
			state_nxt = M_IDLE;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			state_r <= M_IDLE;
		else
			state_r <= state_nxt;
	end

	////////////////////////////////////////////////////////////////////////////
	// Shift register, shared by both roles.

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			bit_r <= 1'b0;
		else if (edge_go & sample_edge)
			bit_r <= in_bit;
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			sh_r <= BYTE_RST;
		else if (load_sw)
			sh_r <= tx_data_r; // see R2, R5
		else if (last_edge & is_slv)
			sh_r <= tx_data_r; // see R6
		else if (last_edge)
			sh_r <= done_byte;
		else if (edge_go & shift_edge)
			sh_r <= {sh_r[BYTE_W-2:0], bit_r}; // see R20
	end

	// Hardware setting the flag beats a same-cycle software data write.
	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
			tx_empty_r <= TX_EMPTY_RST;
		else if (load_sw | (last_edge & is_slv))
			tx_empty_r <= 1'b1; // see R2, R6
		else if (tx_data_wr)
			tx_empty_r <= 1'b0; // see R4
	end

	////////////////////////////////////////////////////////////////////////////
	// Receive path. A slave byte that finds the FIFO full is dropped.

	spigp_fifo #(
		.W(BYTE_W),
		.DEPTH(RX_FIFO_DEPTH)
	) u_rx_fifo (
		.clk(clk_sys),
		.rst_n(rst_n),
		.in_valid(last_edge),
		.in_ready(fifo_in_ready),
		.in_data(done_byte),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	assign fifo_out_ready = serial_mode_select & (~rx_full_r | rx_data_rd);
	assign pop = fifo_out_valid & fifo_out_ready;

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			rx_full_r <= 1'b0;
			rx_irq_r <= 1'b0;
			rx_byte_r <= BYTE_RST;
		end
		else
		begin
			rx_irq_r <= pop; // see R17
			if (pop)
				rx_full_r <= 1'b1;
			else if (rx_data_rd)
				rx_full_r <= 1'b0; // see R3
			if (pop)
				rx_byte_r <= fifo_out_data; // see R19
			else if (!serial_mode_select)
				rx_byte_r <= {{(BYTE_W-PAD_N){1'b0}}, pad_s}; // see R12
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pad steering.

	always_comb
	begin
		oe_nxt = dir_r; // see R8, R9
		out_nxt = tx_data_r[PAD_N-1:0]; // see R11, R16
		if (is_mst)
		begin
			oe_nxt = MST_OE;
			out_nxt = '0;
			out_nxt[PAD_NSS] = slave_select_ctl; // see R16
			out_nxt[PAD_MOSI] = sh_r[BYTE_W-1];
			out_nxt[PAD_SCK] = clock_polarity ^ sck_r;
		end
		else if (is_slv)
		begin
			oe_nxt = '0;
			out_nxt = '0;
			oe_nxt[PAD_MISO] = ~pad_s[PAD_NSS];
			out_nxt[PAD_MISO] = sh_r[BYTE_W-1];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pad_out_r <= '0;
			pad_oe_r <= DIR_RST;
			pull_r <= PULLUP_RST;
			pad_in_r <= PAD_SYNC_RST;
		end
		else
		begin
			pad_out_r <= out_nxt;
			pad_oe_r <= oe_nxt;
			pull_r <= pullup_r & ~oe_nxt; // see R13, R15
			pad_in_r <= pad_s; // see R12
		end
	end

	assign pad_out = pad_out_r;
	assign pad_oe = pad_oe_r;
	assign pad_pullup_en = pull_r;
	assign tx_empty_flag = tx_empty_r;
	assign rx_full_flag = rx_full_r;
	assign rx_irq = rx_irq_r;
	assign rx_data_reg = rx_byte_r;
	assign pad_input_reg = pad_in_r;
	assign pad_direction_reg = dir_r;
	assign pad_pullup_reg = pullup_r;
endmodule : spigp_top

// File: test/spigp_top_props.sv
// Port-level checker for spigp_top, attached by bind below.
// Assumes only the top ports are visible; every check runs on clk_sys.
`timescale 1ns/10ps
module spigp_chk (
	input wire logic clk_sys,
	input wire logic resetn,
	input wire logic pconf_resetn,
	input wire logic serial_mode_select,
	input wire logic master_select,
	input wire logic clock_polarity,
	input wire logic tx_data_wr,
	input wire logic tx_trigger_wr,
	input wire logic rx_data_rd,
	input wire logic [spigp_pkg::PAD_N-1:0] pad_in,
	input wire logic [spigp_pkg::PAD_N-1:0] pad_out,
	input wire logic [spigp_pkg::PAD_N-1:0] pad_oe,
	input wire logic [spigp_pkg::PAD_N-1:0] pad_pullup_en,
	input wire logic tx_empty_flag,
	input wire logic rx_full_flag,
	input wire logic rx_irq,
	input wire logic [spigp_pkg::PAD_N-1:0] pad_input_reg,
	input wire logic [spigp_pkg::PAD_N-1:0] pad_direction_reg,
	input wire logic [spigp_pkg::PAD_N-1:0] pad_pullup_reg
);
	import spigp_pkg::*;
	logic [2:0] live_cnt_r;
	logic live;
	// Checks wait until the internal reset copy and the pad synchroniser are flushed.
	always_ff @(posedge clk_sys or negedge resetn)
	begin
		if (!resetn)
			live_cnt_r <= 3'h0;
		else if (!live)
			live_cnt_r <= live_cnt_r + 3'h1;
	end
	assign live = (live_cnt_r == 3'h6);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!live);
	cfg_reset_a: assert property (!pconf_resetn
		|-> pad_direction_reg == DIR_RST && pad_pullup_reg == PULLUP_RST)
		else $error("config bits not at reset value");
	pull_follow_a: assert property ($stable(pad_pullup_reg)
		|-> pad_pullup_en == (pad_pullup_reg & ~pad_oe))
		else $error("pull-up enable wrong");
	port_dir_a: assert property (!serial_mode_select && !$past(serial_mode_select)
		|-> pad_oe == $past(pad_direction_reg))
		else $error("pad drive does not follow direction");
	rx_clear_a: assert property (rx_data_rd && serial_mode_select |=> !rx_full_flag || rx_irq)
		else $error("read did not clear rx full");
	irq_rise_a: assert property ($rose(rx_full_flag) |-> rx_irq)
		else $error("rx full set without interrupt");
	tx_drop_a: assert property (tx_data_wr && !tx_trigger_wr
		&& !(serial_mode_select && !master_select) |=> !tx_empty_flag)
		else $error("tx empty not cleared by write");
	trig_set_a: assert property (tx_trigger_wr && serial_mode_select |=> tx_empty_flag)
		else $error("trigger did not set tx empty");
	mst_pads_a: assert property ((serial_mode_select && master_select) [*3]
		|-> pad_oe == MST_OE)
		else $error("master pad drive wrong");
	sck_idle_a: assert property (serial_mode_select && master_select && rx_irq
		|-> pad_out[PAD_SCK] == clock_polarity)
		else $error("serial clock not idle after byte");
	pad_direct_a: assert property (pad_input_reg == $past(pad_in, 3))
		else $error("pad input register not direct");
endmodule : spigp_chk
bind spigp_top spigp_chk chk_i (.clk_sys, .resetn, .pconf_resetn, .serial_mode_select,
	.master_select, .clock_polarity, .tx_data_wr, .tx_trigger_wr, .rx_data_rd, .pad_in,
	.pad_out, .pad_oe, .pad_pullup_en, .tx_empty_flag, .rx_full_flag, .rx_irq,
	.pad_input_reg, .pad_direction_reg, .pad_pullup_reg);

// File: test/spigp_peer.sv
// Behavioural serial slave that answers the block while it runs as master.
// Assumes clock phase 0; the bench folds the clock polarity out, so sck idles low.
`timescale 1ns/10ps
module spigp_peer (
	input wire logic sck,
	input wire logic nss,
	input wire logic mosi,
	input wire logic [7:0] load_byte,
	output logic miso,
	output logic [7:0] got
);
	logic [7:0] sh = 8'h00;
	logic in_bit = 1'b0;
	always @(negedge nss)
		sh = load_byte;
	always @(posedge sck)
		if (!nss)
			in_bit = mosi;
	always @(negedge sck)
		if (!nss)
			sh = {sh[6:0], in_bit};
	// A released line shows the inverse so a stale value cannot pass for data.
	assign miso = nss ? ~sh[7] : sh[7];
	assign got = sh;
endmodule : spigp_peer

// File: test/test_spigp_top.sv
// Self-checking bench for spigp_top: pad port, master and slave byte transfers.
// Assumes spigp_peer answers in master mode; the bench plays master in slave mode.
`timescale 1ns/10ps
module test_spigp_top;
	import spigp_pkg::*;
	localparam int WR_TX = 0, TRIG = 1, RD_RX = 2, WR_DIR = 3, WR_PULL = 4;
	logic clk_sys = 1'b0, resetn = 1'b0, pconf_resetn = 1'b0, serial_mode_select = 1'b0;
	logic master_select = 1'b0, clock_phase = 1'b0, clock_polarity = 1'b0;
	logic slave_select_ctl = 1'b1, clear_counters = 1'b0, tx_data_wr = 1'b0;
	logic tx_trigger_wr = 1'b0, rx_data_rd = 1'b0, pad_direction_wr = 1'b0, pad_pullup_wr = 1'b0;
	logic [1:0] baud_rate = 2'h0;
	logic [BYTE_W-1:0] tx_data_in = 8'h00, peer_load = 8'h00;
	logic [PAD_N-1:0] pad_direction_in = 4'h0, pad_pullup_in = 4'h0, tb_drv = 4'h8, tb_drv_en = 4'h0;
	logic [PAD_N-1:0] pad_in, pad_out, pad_oe, pad_pullup_en, drv, drv_en;
	logic [PAD_N-1:0] pad_input_reg, pad_direction_reg, pad_pullup_reg;
	logic tx_empty_flag, rx_full_flag, rx_irq, peer_miso, peer_on;
	logic [BYTE_W-1:0] rx_data_reg, peer_got, mi;
	logic [7:0] mst_tx [2] = '{8'ha5, 8'h71};
	logic [7:0] mst_peer [2] = '{8'h3c, 8'h8e};
	logic [7:0] slv_mo [3] = '{8'hc3, 8'h81, 8'h6b};
	logic [7:0] slv_exp [3] = '{8'h96, 8'h5a, 8'h5a};
	int num_errors = 0;
	int n_checks = 0;
	int cycles = 0;
	assign peer_on = serial_mode_select & master_select;
	assign drv = {tb_drv[3:2], peer_on ? peer_miso : tb_drv[1], tb_drv[0]};
	assign drv_en = peer_on ? 4'h2 : tb_drv_en;
	// An undriven pad settles to its pull-up, or low without one.
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & drv_en & drv)
		| (~pad_oe & ~drv_en & pad_pullup_en);
	always #5 clk_sys = ~clk_sys;
	spigp_top dut (.clk_sys, .resetn, .pconf_resetn, .serial_mode_select, .master_select,
		.clock_phase, .clock_polarity, .baud_rate, .slave_select_ctl, .clear_counters,
		.tx_data_wr, .tx_data_in, .tx_trigger_wr, .rx_data_rd, .pad_direction_wr,
		.pad_direction_in, .pad_pullup_wr, .pad_pullup_in, .pad_in, .pad_out, .pad_oe,
		.pad_pullup_en, .tx_empty_flag, .rx_full_flag, .rx_irq, .rx_data_reg,
		.pad_input_reg, .pad_direction_reg, .pad_pullup_reg);
	spigp_peer peer (.sck(pad_in[PAD_SCK] ^ clock_polarity), .nss(pad_in[PAD_NSS]),
		.mosi(pad_in[PAD_MOSI]),
		.load_byte(peer_load), .miso(peer_miso), .got(peer_got));
	////////////////////////////////////////////////////////////////////////////////
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask : tick
	task automatic chk_v(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : chk_v
	task automatic chk_f(input string what, input logic exp, input logic got);
		n_checks++;
		if (got !== exp)
		begin
			num_errors++;
			$display("FAIL %s expected %b seen %b", what, exp, got);
		end
	endtask : chk_f
	// One software access: a one-cycle strobe, with an idle cycle before it.
	task automatic sw(input int k, input logic [7:0] d);
		tick();
		tx_data_in = d;
		pad_direction_in = d[3:0];
		pad_pullup_in = d[3:0];
		tx_data_wr = (k == WR_TX);
		tx_trigger_wr = (k == TRIG);
		rx_data_rd = (k == RD_RX);
		pad_direction_wr = (k == WR_DIR);
		pad_pullup_wr = (k == WR_PULL);
		tick();
		{tx_data_wr, tx_trigger_wr, rx_data_rd, pad_direction_wr, pad_pullup_wr} = 5'h00;
	endtask : sw
	task automatic wait_full(input int n);
		int i;
		i = 0;
		while (rx_full_flag !== 1'b1 && i < n)
		begin
			tick();
			i++;
		end
		chk_f("rx_full", 1'b1, rx_full_flag);
	endtask : wait_full
	// Bench as master, phase from clock_phase, idle-low clock, 125 ns per bit.
	task automatic spi_xfer(input logic [7:0] mo, output logic [7:0] got);
		tb_drv[PAD_NSS] = 1'b0;
		#250;
		for (int k = 7; k >= 0; k--)
		begin
			if (!clock_phase)
				tb_drv[PAD_MOSI] = mo[k];
			#62.5 tb_drv[PAD_SCK] = 1'b1;
			if (clock_phase)
				tb_drv[PAD_MOSI] = mo[k];
			else
				got[k] = pad_in[PAD_MISO];
			#62.5 tb_drv[PAD_SCK] = 1'b0;
			if (clock_phase)
				got[k] = pad_in[PAD_MISO];
		end
		#250 tb_drv[PAD_NSS] = 1'b1;
		#250;
	endtask : spi_xfer
	task stop_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : stop_test
	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			num_errors++;
			stop_test();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		repeat (3) tick();
		resetn = 1'b1;
		pconf_resetn = 1'b1;
		repeat (3) tick();
		chk_v("dir_reg", 8'h00, {4'h0, pad_direction_reg});
		chk_v("pullup_en", 8'h0f, {4'h0, pad_pullup_en});
		tb_drv_en = 4'ha;
		sw(WR_TX, 8'h36);
		chk_f("tx_empty", 1'b0, tx_empty_flag);
		sw(TRIG, 8'h00);
		chk_f("tx_empty", 1'b0, tx_empty_flag);
		sw(WR_DIR, 8'h05);
		sw(WR_PULL, 8'h0f);
		repeat (4) tick();
		chk_v("pad_oe", 8'h05, {4'h0, pad_oe});
		chk_v("pad_out", 8'h04, {4'h0, pad_out & pad_oe});
		chk_v("pullup_en", 8'h0a, {4'h0, pad_pullup_en});
		chk_v("pad_input", 8'h0c, {4'h0, pad_input_reg});
		chk_v("rx_port", 8'h0c, rx_data_reg);
		pconf_resetn = 1'b0;
		repeat (2) tick();
		chk_v("dir_reg", 8'h00, {4'h0, pad_direction_reg});
		pconf_resetn = 1'b1;
		serial_mode_select = 1'b1;
		master_select = 1'b1;
		repeat (3) tick();
		for (int i = 0; i < 2; i++)
		begin
			// Polarity changes while the peer is deselected, one cycle ahead of the select.
			clock_polarity = (i == 1);
			tick();
			baud_rate = (i == 0) ? 2'h0 : 2'h3;
			peer_load = mst_peer[i];
			slave_select_ctl = 1'b0;
			sw(WR_TX, mst_tx[i]);
			chk_f("tx_empty", 1'b0, tx_empty_flag);
			sw(TRIG, 8'h00);
			chk_f("tx_empty", 1'b1, tx_empty_flag);
			wait_full(600);
			chk_v("rx_data", mst_peer[i], rx_data_reg);
			chk_v("peer_got", mst_tx[i], peer_got);
			sw(RD_RX, 8'h00);
			chk_f("rx_full", 1'b0, rx_full_flag);
			slave_select_ctl = 1'b1;
			repeat (3) tick();
		end
		master_select = 1'b0;
		clock_polarity = 1'b0;
		tb_drv_en = 4'hd;
		sw(WR_PULL, 8'h09);
		repeat (2) tick();
		chk_v("pullup_en", 8'h09, {4'h0, pad_pullup_en});
		sw(WR_TX, 8'h96);
		sw(TRIG, 8'h00);
		sw(WR_TX, 8'h5a);
		// Clock edges while the select is high, or while the counters are cleared, must not
		// count; a shifted register would show up in the first returned byte.
		for (int p = 0; p < 6; p++)
		begin
			if (p == 3)
			begin
				tick();
				clear_counters = 1'b1;
				tb_drv[PAD_NSS] = 1'b0;
			end
			#62.5 tb_drv[PAD_SCK] = 1'b1;
			#62.5 tb_drv[PAD_SCK] = 1'b0;
		end
		tb_drv[PAD_NSS] = 1'b1;
		repeat (3) tick();
		clear_counters = 1'b0;
		for (int j = 0; j < 3; j++)
		begin
			clock_phase = (j == 2);
			spi_xfer(slv_mo[j], mi);
			wait_full(20);
			chk_v("rx_data", slv_mo[j], rx_data_reg);
			chk_v("miso_byte", slv_exp[j], mi);
			chk_f("tx_empty", 1'b1, tx_empty_flag);
			sw(RD_RX, 8'h00);
		end
		stop_test();
	end
endmodule : test_spigp_top
